//--- common/clk_pkg.sv
`default_nettype none
package clk_pkg;

   // register byte offsets
   localparam logic [11:0] RATIO_OFFSET  = 12'h000;
   localparam logic [11:0] INTEN_OFFSET  = 12'h004;
   localparam logic [11:0] FLAG_OFFSET   = 12'h008;
   localparam logic [11:0] STATUS_OFFSET = 12'h00c;
   localparam logic [11:0] MASK_OFFSET   = 12'h010;

   // field positions
   localparam int READY_BIT      = 0;  // ready flag / ready enable
   localparam int PENDING_BIT    = 0;  // status: ratio change in flight
   localparam int EFF_RATIO_LSB  = 8;  // status: ratio now in use
   localparam int COMPARATOR_BIT = 0;  // mask bit of comparator_bus_clock
   localparam int CONVERTER0_BIT = 1;  // mask bit of converter0_bus_clock

   // widths
   localparam int RATIO_W = 8;
   localparam int MASK_W  = 8;

   // reset values
   localparam logic [RATIO_W-1:0] RATIO_RESET = 8'h01;  // undivided
   localparam logic [MASK_W-1:0]  MASK_RESET  = 8'hfc;  // comparator, converter0 off
   localparam logic               INTEN_RESET = 1'b0;
   localparam logic               FLAG_RESET  = 1'b1;

   // a ratio is legal when it is a nonzero power of two
   function automatic logic ratio_legal(input logic [RATIO_W-1:0] r);
      logic [RATIO_W-1:0] rm1;
      rm1 = r - 8'h01;
      return (r != 8'h00) && ((r & rm1) == 8'h00);
   endfunction

endpackage
`default_nettype wire

//--- common/presc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface presc_if;
   import clk_pkg::*;

   logic [RATIO_W-1:0] new_ratio;  // ratio to apply
   logic               load;       // one-cycle request to apply new_ratio
   logic               done;       // one-cycle pulse: new ratio in effect
   logic [RATIO_W-1:0] eff_ratio;  // ratio now in use
   logic [MASK_W-1:0]  mask;       // bus clock mask bits

   modport ctrl (output new_ratio, output load, output mask,
                 input done, input eff_ratio);
   modport core (input new_ratio, input load, input mask,
                 output done, output eff_ratio);
endinterface
`default_nettype wire

//--- rtl/cpu_ratio_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_ratio_prescaler
   import clk_pkg::*;
(
   input  wire logic              pclk,        // main_clock_input
   input  wire logic              presetn,     // async reset, active low
   presc_if.core                  pif,         // control from register file
   output logic                   cpu_tick,    // cpu domain clock enable
   output logic [MASK_W-1:0]      bus_clk_en   // gated peripheral enables
);

   logic [RATIO_W-1:0] eff_q,  eff_d;
   logic [RATIO_W-1:0] cnt_q,  cnt_d;
   logic [RATIO_W-1:0] nxt_q,  nxt_d;
   logic               pend_q, pend_d;
   logic               done_q, done_d;
   logic               tick_q, tick_d;
   logic [MASK_W-1:0]  en_q,   en_d;
   logic               wrap;

   // a change stays pending from the load until the boundary swap
   function automatic logic pend_pick();
      return pend_q | pif.load;
   endfunction

   // 8-bit prescaler; a period ends when the counter reaches ratio-1
   always_comb
   begin
      wrap   = (cnt_q == eff_q - 8'h01);
      cnt_d  = wrap ? 8'h00 : cnt_q + 8'h01;
      eff_d  = eff_q;
      nxt_d  = nxt_q;
      pend_d = pend_pick();
      done_d = 1'b0;
      if (pif.load)
      begin
         nxt_d = pif.new_ratio;
      end
      // switch only on a period boundary so no period is cut short
      if (pend_q && wrap)
      begin
         eff_d  = nxt_q;
         pend_d = 1'b0;
         done_d = 1'b1;
      end
      // one shared tick, so every derived enable moves together
      tick_d = (cnt_d == 8'h00);
      en_d   = tick_d ? pif.mask : '0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         eff_q  <= RATIO_RESET;
         cnt_q  <= 8'h00;
         nxt_q  <= RATIO_RESET;
         pend_q <= 1'b0;
         done_q <= 1'b0;
         tick_q <= 1'b0;
         en_q   <= '0;
      end
      else
      begin
         eff_q  <= eff_d;
         cnt_q  <= cnt_d;
         nxt_q  <= nxt_d;
         pend_q <= pend_d;
         done_q <= done_d;
         tick_q <= tick_d;
         en_q   <= en_d;
      end
   end

   assign cpu_tick      = tick_q;
   assign bus_clk_en    = en_q;
   assign pif.done      = done_q;
   assign pif.eff_ratio = eff_q;

endmodule
`default_nettype wire

//--- rtl/cpu_clock_prescaler_mask.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_prescaler_mask
   import clk_pkg::*;
#(
   parameter int ADDR_W = 12     // apb address width
)
(
   input  wire logic              pclk,             // main_clock_input
   input  wire logic              presetn,          // async reset, active low
   input  wire logic              psel,             // apb select
   input  wire logic              penable,          // apb access phase
   input  wire logic              pwrite,           // apb direction
   input  wire logic [ADDR_W-1:0] paddr,            // apb byte address
   input  wire logic [31:0]       pwdata,           // apb write data
   output logic [31:0]            prdata,           // apb read data
   output logic                   pready,           // apb ready
   output logic                   pslverr,          // apb error
   output logic                   cpu_tick,         // cpu domain clock enable
   output logic [MASK_W-1:0]      bus_clk_en,       // per-peripheral enables
   output logic                   ready_irq,        // clock ready interrupt
   output logic                   access_violation  // to access_controller
);

   presc_if pif ();

   // register state
   logic [RATIO_W-1:0] ratio_q, ratio_d;   // cpu_ratio_register
   logic               inten_q, inten_d;   // interrupt_enable_set
   logic               flag_q,  flag_d;    // clock_ready_flag
   logic               pend_q,  pend_d;    // change in flight
   logic [MASK_W-1:0]  mask_q,  mask_d;    // bus_clock_mask
   logic               viol_q,  viol_d;
   logic               load_q,  load_d;
   logic [31:0]        rdata_q, rdata_d;
   logic               err_q,   err_d;

   // bus decode
   logic              setup_ph;
   logic              wr_take;
   logic [11:0]       offs;
   logic              hit;
   logic [31:0]       rd_mux;

   assign setup_ph = psel && !penable;
   assign wr_take  = psel && penable && pwrite;   // pready is always high
   assign offs     = 12'(paddr);

   // address decode and read mux, evaluated during the setup phase
   always_comb
   begin
      hit    = 1'b1;
      rd_mux = 32'h0000_0000;
      case (offs)
         RATIO_OFFSET:
         begin
            rd_mux[RATIO_W-1:0] = ratio_q;
         end
         INTEN_OFFSET:
         begin
            rd_mux[READY_BIT] = inten_q;
         end
         FLAG_OFFSET:
         begin
            rd_mux[READY_BIT] = flag_q;
         end
         STATUS_OFFSET:
         begin
            rd_mux[PENDING_BIT] = pend_q;
            rd_mux[EFF_RATIO_LSB +: RATIO_W] = pif.eff_ratio;
         end
         MASK_OFFSET:
         begin
            rd_mux[MASK_W-1:0] = mask_q;
         end
         default:
         begin
            hit = 1'b0;
         end
      endcase
   end

   // apb answer: data and error captured in setup, shown in access
   always_comb
   begin
      rdata_d = rdata_q;
      err_d   = err_q;
      if (setup_ph)
      begin
         rdata_d = pwrite ? 32'h0000_0000 : rd_mux;
         err_d   = !hit;
      end
   end

   // register writes and the ratio change handshake
   always_comb
   begin
      ratio_d = ratio_q;
      inten_d = inten_q;
      mask_d  = mask_q;
      flag_d  = flag_q;
      pend_d  = pend_q;
      viol_d  = 1'b0;
      load_d  = 1'b0;
      if (wr_take)
      begin
         case (offs)
            RATIO_OFFSET:
            begin
               // value is always stored; it is only forwarded when safe
               ratio_d = pwdata[RATIO_W-1:0];
               if (pend_q)
               begin
                  viol_d = 1'b1;
               end
               else if (!ratio_legal(pwdata[RATIO_W-1:0]))
               begin
                  viol_d = 1'b1;
               end
               else
               begin
                  // no halt needed: the prescaler swaps on a boundary
                  load_d = 1'b1;
                  pend_d = 1'b1;
                  flag_d = 1'b0;
               end
            end
            INTEN_OFFSET:
            begin
               inten_d = pwdata[READY_BIT];
            end
            FLAG_OFFSET:
            begin
               if (pwdata[READY_BIT])
               begin
                  flag_d = 1'b0;
               end
            end
            MASK_OFFSET:
            begin
               mask_d = pwdata[MASK_W-1:0];
            end
            default:
            begin
               ratio_d = ratio_q;
            end
         endcase
      end
      // completion sets the flag and wins over a same-cycle clear
      if (pif.done)
      begin
         flag_d = 1'b1;
         pend_d = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ratio_q <= RATIO_RESET;
         inten_q <= INTEN_RESET;
         flag_q  <= FLAG_RESET;
         pend_q  <= 1'b0;
         mask_q  <= MASK_RESET;
         viol_q  <= 1'b0;
         load_q  <= 1'b0;
         rdata_q <= 32'h0000_0000;
         err_q   <= 1'b0;
      end
      else
      begin
         ratio_q <= ratio_d;
         inten_q <= inten_d;
         flag_q  <= flag_d;
         pend_q  <= pend_d;
         mask_q  <= mask_d;
         viol_q  <= viol_d;
         load_q  <= load_d;
         rdata_q <= rdata_d;
         err_q   <= err_d;
      end
   end

   // hand the accepted ratio and the mask to the prescaler
   assign pif.new_ratio = ratio_q;
   assign pif.load      = load_q;
   assign pif.mask      = mask_q;

   cpu_ratio_prescaler u_presc (
      .pclk       (pclk),
      .presetn    (presetn),
      .pif        (pif),
      .cpu_tick   (cpu_tick),
      .bus_clk_en (bus_clk_en)
   );

   // apb outputs; zero wait states keep the slave simple
   assign prdata  = rdata_q;
   assign pready  = 1'b1;
   assign pslverr = err_q && psel && penable;

   // interrupt follows the sticky flag gated by its enable
   assign ready_irq        = flag_q && inten_q;
   assign access_violation = viol_q;

endmodule
`default_nettype wire

//--- bench/cpu_clock_prescaler_mask_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_prescaler_mask_chk
   import clk_pkg::*;
#(
   parameter int ADDR_W = 12  // apb address width
)
(
   input wire logic              pclk,             // clock
   input wire logic              presetn,          // reset, low
   input wire logic              psel,             // select
   input wire logic              penable,          // access phase
   input wire logic              pwrite,           // direction
   input wire logic [ADDR_W-1:0] paddr,            // address
   input wire logic [31:0]       pwdata,           // write data
   input wire logic [31:0]       prdata,           // read data
   input wire logic              pready,           // ready
   input wire logic              pslverr,          // error
   input wire logic              cpu_tick,         // cpu enable
   input wire logic [MASK_W-1:0] bus_clk_en,       // bus enables
   input wire logic              ready_irq,        // ready irq
   input wire logic              access_violation  // violation
);
   logic       rat_wr, any_wr;
   logic [8:0] gap_q;
   logic       up_q, rw_q, mw_q;

   // decoded write strobes
   assign rat_wr = psel && penable && pwrite && paddr == RATIO_OFFSET;
   assign any_wr = rat_wr || (psel && penable && pwrite
                   && (paddr == FLAG_OFFSET || paddr == INTEN_OFFSET));

   // gap saturates so a stuck tick cannot wrap back to a legal count
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         gap_q <= 9'h000;
         up_q  <= 1'b0;
         rw_q  <= 1'b0;
         mw_q  <= 1'b0;
      end
      else
      begin
         gap_q <= cpu_tick ? 9'h000 : gap_q + {8'h00, gap_q != 9'h1ff};
         up_q  <= 1'b1;
         rw_q  <= rw_q || rat_wr;
         mw_q  <= mw_q || (psel && penable && pwrite && paddr == MASK_OFFSET);
      end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_tick_gap: assert property (gap_q < 9'h082)
      else $error("cpu tick gap too long");
   chk_undivided: assert property (up_q && !rw_q |-> cpu_tick)
      else $error("tick missing before ratio write");
   chk_bad_ratio: assert property
      (rat_wr && $countones(pwdata[RATIO_W-1:0]) != 1 |=> access_violation)
      else $error("bad ratio not reported");
   chk_no_wait: assert property (psel |-> pready)
      else $error("slave stalled");
   chk_en_aligned: assert property (|bus_clk_en |-> cpu_tick)
      else $error("bus enable off the tick");
   chk_viol_cause: assert property
      (access_violation |-> $past(rat_wr))
      else $error("violation without ratio write");
   chk_mask_reset: assert property
      (!mw_q |-> bus_clk_en == (cpu_tick ? MASK_RESET : 8'h00))
      else $error("default mask wrong");
   chk_flag_clear: assert property
      ($fell(ready_irq) |-> $past(any_wr) || $past(any_wr, 2))
      else $error("ready irq fell on its own");

   cover property (access_violation);
   cover property ($rose(ready_irq));
   cover property (mw_q && bus_clk_en[1]);
endmodule

bind cpu_clock_prescaler_mask cpu_clock_prescaler_mask_chk #(.ADDR_W(ADDR_W))
   u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .cpu_tick(cpu_tick),
   .bus_clk_en(bus_clk_en), .ready_irq(ready_irq),
   .access_violation(access_violation));
`default_nettype wire

//--- bench/cpu_clock_prescaler_mask_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_prescaler_mask_tb;
   import clk_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, cpu_tick, ready_irq, access_violation;
   logic [7:0]  bus_clk_en;
   int          mismatches = 0, n_checks = 0, n_viol = 0, n, n0;

   always #5 pclk = ~pclk;

   // pulses counted here since they stand for one cycle only
   always @(posedge pclk)
      if (access_violation === 1'b1)
         n_viol++;

   cpu_clock_prescaler_mask #(.ADDR_W(12)) u_cpu_clock_prescaler_mask
      (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
       .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
       .pready(pready), .pslverr(pslverr), .cpu_tick(cpu_tick),
       .bus_clk_en(bus_clk_en), .ready_irq(ready_irq),
       .access_violation(access_violation));

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
   endtask

   // edges until the tick or the ready irq is seen; a hang ends the run
   task automatic wait_hi(input bit irq, output int cnt);
      cnt = 0;
      do
      begin
         @(posedge pclk);
         cnt++;
      end
      while ((irq ? ready_irq : cpu_tick) !== 1'b1 && cnt < 400);
      if ((irq ? ready_irq : cpu_tick) !== 1'b1)
      begin
         mismatches++;
         tally_and_finish();
      end
   endtask

   // one apb transfer; read data taken at the edge that sees pready
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         mismatches++;
         tally_and_finish();
      end
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask

   task automatic period(input logic [7:0] r);
      wait_hi(1'b0, n);
      wait_hi(1'b0, n);
      check(32'(n), {24'h0, r});
   endtask

   // start aligned to a tick so a long old period leaves time to look
   task automatic setr(input logic [7:0] r, input bit busy);
      apb(1'b1, FLAG_OFFSET, 32'h1);
      wait_hi(1'b0, n);
      apb(1'b1, RATIO_OFFSET, {24'h0, r});
      if (busy)
         rdchk(FLAG_OFFSET, 32'h0);
      wait_hi(1'b1, n);
      rdchk(STATUS_OFFSET, {16'h0, r, 8'h00});
      period(r);
   endtask

   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(RATIO_OFFSET, 32'h1);
      rdchk(INTEN_OFFSET, 32'h0);
      check({31'h0, ready_irq}, 32'h0);
      rdchk(STATUS_OFFSET, 32'h100);
      rdchk(MASK_OFFSET, 32'hfc);
      apb(1'b0, 12'h040, 32'h0);
      check({rd[30:0], err}, 32'h1);
      period(8'h01);
      apb(1'b1, FLAG_OFFSET, 32'h0);
      rdchk(FLAG_OFFSET, 32'h1);
      apb(1'b1, FLAG_OFFSET, 32'h1);
      rdchk(FLAG_OFFSET, 32'h0);
      apb(1'b1, INTEN_OFFSET, 32'h1);
      setr(8'h40, 1'b0);
      for (int i = 7; i >= 0; i--)
         setr(8'h01 << i, i >= 2);
      // forbidden values stay readable but leave the divider alone
      n0 = n_viol;
      apb(1'b1, RATIO_OFFSET, 32'h3);
      rdchk(RATIO_OFFSET, 32'h3);
      apb(1'b1, RATIO_OFFSET, 32'h0);
      rdchk(STATUS_OFFSET, 32'h100);
      check(32'(n_viol - n0), 32'h2);
      setr(8'h20, 1'b0);
      apb(1'b1, FLAG_OFFSET, 32'h1);
      wait_hi(1'b0, n);
      n0 = n_viol;
      apb(1'b1, RATIO_OFFSET, 32'h4);
      apb(1'b1, RATIO_OFFSET, 32'h8);
      wait_hi(1'b1, n);
      rdchk(STATUS_OFFSET, 32'h400);
      check(32'(n_viol - n0), 32'h1);
      for (int m = 1; m <= 2; m++)
      begin
         apb(1'b1, MASK_OFFSET, 32'(m));
         wait_hi(1'b0, n);
         wait_hi(1'b0, n);
         check({24'h0, bus_clk_en}, 32'(m));
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
